// File: verilog/frc_cmd.sv
/*
  Command interpreter for resume, no-operation, two-step software reset and
  parameter-space header reads. Serial logic runs on the link clock SCLK;
  resulting events cross to SYS_CLK by toggles.
  Assumes the host keeps SCLK quiet while chip select is high, and that the
  flash core drives the busy/suspend inputs on SYS_CLK.
*/
`timescale 1ns/100ps
module frc_cmd
  import frc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A,  // arbitrary neutral maker code
  parameter int GUARD_CYC = frc_pkg::RESUME_GUARD_CYC
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] SIO_IN,
  output logic [3:0] SIO_OUT,
  output logic [3:0] SIO_OE,
  input wire logic FOUR_LINE_MODE,
  input wire logic ENHANCED_MODE,
  input wire logic PROGRAM_SUSPENDED_SET,
  input wire logic ERASE_SUSPENDED_SET,
  input wire logic CORE_BUSY,
  input wire logic WRITE_ENABLE_SET,
  output logic [7:0] SECURITY_STATUS,
  output logic BUSY,
  output logic WRITE_ENABLE_LATCH,
  output logic RESUME_PULSE,
  output logic SOFT_RESET_PULSE,
  output logic SUSPEND_ALLOWED
);
  import frc_pkg::*;

  typedef enum {FRC_OPC, FRC_ADDR, FRC_DUMMY, FRC_DATA, FRC_SKIP} frc_phase_e;

  localparam int GUARD_W = $clog2(GUARD_CYC + 1);

  // the guard check below counts eight cycles, so shorter guards are refused
  if (GUARD_CYC < 8) begin : g_guard_check
    $error("GUARD_CYC must be at least 8");
  end

  function automatic logic [7:0] ps_byte(input logic [7:0] a);
    case (a)
      8'h00: ps_byte = PS_SIGNATURE[7:0];
      8'h01: ps_byte = PS_SIGNATURE[15:8];
      8'h02: ps_byte = PS_SIGNATURE[23:16];
      8'h03: ps_byte = PS_SIGNATURE[31:24];
      8'h04: ps_byte = PS_MINOR_REV;
      8'h05: ps_byte = PS_MAJOR_REV;
      8'h06: ps_byte = PS_HDR_COUNT;
      8'h08: ps_byte = PS_STD_ID;
      8'h09: ps_byte = PS_MINOR_REV;
      8'h0A: ps_byte = PS_MAJOR_REV;
      8'h0B: ps_byte = PS_T0_LEN;
      8'h0C: ps_byte = PS_T0_PTR;
      8'h0D: ps_byte = 8'h00;
      8'h0E: ps_byte = 8'h00;
      8'h10: ps_byte = MAKER_ID;
      8'h11: ps_byte = PS_MINOR_REV;
      8'h12: ps_byte = PS_MAJOR_REV;
      8'h13: ps_byte = PS_T1_LEN;
      8'h14: ps_byte = PS_T1_PTR;
      8'h15: ps_byte = 8'h00;
      8'h16: ps_byte = 8'h00;
      default: ps_byte = PS_RESERVED;
    endcase
  endfunction

  // link domain: async cleared by chip select, no edge is needed after a frame
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [1:0] byte_cnt_r;
  frc_phase_e phase_r;
  logic [7:0] opc_r;
  logic [23:0] addr_r;
  logic [7:0] out_r;
  logic out_en_r;

  logic quad;
  logic [7:0] shift_nxt;
  logic [2:0] step;
  logic byte_done;
  // line mode is quasi-static: it only changes between frames, so the link
  // logic reads it without a synchroniser of its own
  assign quad = FOUR_LINE_MODE;
  assign step = quad ? 3'h4 : 3'h1;
  // single-line mode ignores the upper lines
  assign shift_nxt = quad ? {shift_r[3:0], SIO_IN} : {shift_r[6:0], SIO_IN[0]};
  // the counter wraps to zero exactly when a whole byte has been shifted
  assign byte_done = 3'(bit_cnt_r + step) == 3'h0;

  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt_r <= 3'd0;
      byte_cnt_r <= 2'd0;
      phase_r <= FRC_OPC;
      opc_r <= 8'h00;
      addr_r <= 24'h0;
      shift_r <= 8'h00;
    end else begin
      bit_cnt_r <= 3'(bit_cnt_r + step);
      shift_r <= shift_nxt;
      if (byte_done) begin
        case (phase_r)
          FRC_OPC: begin
            opc_r <= shift_nxt;
            phase_r <= (shift_nxt == OP_PSREAD) ? FRC_ADDR : FRC_SKIP;
          end
          FRC_ADDR: begin
            addr_r <= {addr_r[15:0], shift_nxt};
            byte_cnt_r <= 2'(byte_cnt_r + 2'd1);
            if (byte_cnt_r == 2'(PS_ADDR_BYTES - 1)) phase_r <= FRC_DUMMY;
          end
          FRC_DUMMY: phase_r <= FRC_DATA;
          FRC_DATA: addr_r <= 24'(addr_r + 24'd1);
          default: phase_r <= FRC_SKIP;
        endcase
      end
    end
  end

  // a data bit changes on the falling edge so the host samples it on the rising
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      out_r <= 8'h00;
      out_en_r <= 1'b0;
    end else if (phase_r == FRC_DATA) begin
      out_en_r <= 1'b1;
      if (bit_cnt_r == 3'd0) begin
        // any address past the header, upper bytes included, reads as reserved
        out_r <= ps_byte((addr_r > 24'(PS_HDR_LAST)) ? 8'hFF : addr_r[7:0]);
      end else begin
        out_r <= quad ? {out_r[3:0], 4'h0} : {out_r[6:0], 1'b0};
      end
    end
  end

  assign SIO_OUT = quad ? out_r[7:4] : {2'b00, out_r[7], 1'b0};
  assign SIO_OE = !out_en_r ? 4'h0 : (quad ? 4'hF : 4'h2);

  // command capture on chip select rise: opcode byte with whole-byte framing
  logic cmd_tgl_r;
  logic [7:0] cmd_op_r;
  logic link_rst_r;
  // the toggle needs a known start; it is cleared from the system reset while
  // chip select is idle, so the release cannot meet a chip select edge
  always_ff @(posedge SYS_CLK) begin
    link_rst_r <= !NRST;
  end
  always_ff @(posedge CS_N or posedge link_rst_r) begin
    if (link_rst_r) begin
      cmd_op_r <= 8'h00;
      cmd_tgl_r <= 1'b0;
    end else if (phase_r == FRC_SKIP && opc_r != OP_PSREAD && bit_cnt_r == 3'd0) begin
      // bit counter is zero only on a byte boundary
      cmd_op_r <= opc_r;
      cmd_tgl_r <= ~cmd_tgl_r;
    end
  end

  // system domain
  logic [2:0] tgl_sync_r;
  logic op_take;
  logic cmd_ev_r;
  logic cmd_ev;
  logic [7:0] cmd_op_sys_r;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) tgl_sync_r <= 3'b000;
    else tgl_sync_r <= {tgl_sync_r[1:0], cmd_tgl_r};
  end
  // only the second and third stages are read, never the metastable first one
  assign op_take = tgl_sync_r[2] ^ tgl_sync_r[1];
  // opcode is stable long before the toggle is seen, a multi-cycle hold;
  // the event is registered so that it lines up with the captured opcode
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cmd_op_sys_r <= 8'h00;
      cmd_ev_r <= 1'b0;
    end else begin
      cmd_ev_r <= op_take;
      if (op_take) cmd_op_sys_r <= cmd_op_r;
    end
  end
  assign cmd_ev = cmd_ev_r;

  logic [1:0] enh_sync_r;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) enh_sync_r <= 2'b00;
    else enh_sync_r <= {enh_sync_r[0], ENHANCED_MODE};
  end

  logic arm_r;
  logic psb_r;
  logic esb_r;
  logic busy_r;
  logic wel_r;
  logic resume_r;
  logic reset_r;
  logic suspended;
  logic do_resume;
  logic do_reset;
  assign suspended = psb_r | esb_r;
  // no write enable latch in the condition
  assign do_resume = cmd_ev && cmd_op_sys_r == OP_RESUME && suspended && !enh_sync_r[1];
  assign do_reset = cmd_ev && cmd_op_sys_r == OP_RESET && arm_r;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST || do_reset) arm_r <= 1'b0;
    else if (cmd_ev) arm_r <= (cmd_op_sys_r == OP_RST_ARM);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST || do_reset) begin
      psb_r <= 1'b0;
      esb_r <= 1'b0;
    end else if (do_resume) begin
      psb_r <= 1'b0;
      esb_r <= 1'b0;
    end else begin
      psb_r <= psb_r | PROGRAM_SUSPENDED_SET;
      esb_r <= esb_r | ERASE_SUSPENDED_SET;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST || do_reset) busy_r <= 1'b0;
    else if (do_resume) busy_r <= 1'b1;
    else busy_r <= CORE_BUSY;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST || do_reset || suspended) wel_r <= 1'b0;
    else if (WRITE_ENABLE_SET) wel_r <= 1'b1;
  end

  // counted on the system clock, so the guard length follows its frequency
  logic [GUARD_W-1:0] guard_r;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || do_reset) guard_r <= '0;
    else if (do_resume) guard_r <= GUARD_W'(GUARD_CYC);
    else if (guard_r != '0) guard_r <= guard_r - 1'b1;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      resume_r <= 1'b0;
      reset_r <= 1'b0;
    end else begin
      resume_r <= do_resume;
      reset_r <= do_reset;
    end
  end

  always_comb begin
    SECURITY_STATUS = 8'h00;
    SECURITY_STATUS[SEC_PSB_BIT] = psb_r;
    SECURITY_STATUS[SEC_ESB_BIT] = esb_r;
  end
  assign BUSY = busy_r;
  assign WRITE_ENABLE_LATCH = wel_r;
  assign RESUME_PULSE = resume_r;
  assign SOFT_RESET_PULSE = reset_r;
  assign SUSPEND_ALLOWED = guard_r == '0;

  // all checks run on the system clock; the link is only watched between frames
  chk_resume_clears: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    do_resume |=> !psb_r && !esb_r && busy_r && resume_r)
    else $error("resume did not clear");
  chk_idle_resume: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    cmd_ev && cmd_op_sys_r == OP_RESUME && !suspended |=> !RESUME_PULSE)
    else $error("resume without suspend");
  chk_resume_busy: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RESUME_PULSE |-> BUSY)
    else $error("busy low after resume");
  chk_resume_single: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RESUME_PULSE |=> !RESUME_PULSE)
    else $error("resume pulse too long");
  chk_reset_needs_arm: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    reset_r |-> $past(arm_r))
    else $error("reset without arm");
  chk_arm_source: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(arm_r) |-> $past(cmd_ev) && $past(cmd_op_sys_r) == OP_RST_ARM)
    else $error("arm without command");
  chk_reset_clears: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    do_reset |=> !arm_r && !busy_r && !psb_r && !wel_r)
    else $error("reset left state");
  chk_reset_single: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    SOFT_RESET_PULSE |=> !SOFT_RESET_PULSE)
    else $error("reset pulse too long");
  chk_enh_blocks: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    cmd_ev && cmd_op_sys_r == OP_RESUME && enh_sync_r[1] |=>
      !RESUME_PULSE && (SECURITY_STATUS & $past(SECURITY_STATUS)) == $past(SECURITY_STATUS))
    else $error("resume in enhanced mode");
  chk_guard_after: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    resume_r |-> !SUSPEND_ALLOWED [*8])
    else $error("guard too short");
  chk_guard_start: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $fell(SUSPEND_ALLOWED) |-> $past(do_resume))
    else $error("guard without resume");
  chk_wel_suspend: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    suspended |=> !wel_r)
    else $error("latch set while suspended");
  chk_nop_disarms: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    cmd_ev && cmd_op_sys_r == OP_NOP |=> !arm_r)
    else $error("nop kept arm");
  chk_oe_cs: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CS_N |-> SIO_OE == 4'h0)
    else $error("drive while deselected");
endmodule // frc_cmd

// File: verilog/frc_pkg.sv
/*
  Constants for the serial flash command block: opcodes, parameter-space
  header layout and timing.
  Assumes a 10 MHz system clock and a host-driven serial clock.
*/
package frc_pkg;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_RST_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_PSREAD = 8'h5A;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam int SEC_PSB_BIT = 2;
  localparam int SEC_ESB_BIT = 3;
  localparam logic [7:0] PS_RESERVED = 8'hFF;
  localparam logic [7:0] PS_MINOR_REV = 8'h00;
  localparam logic [7:0] PS_MAJOR_REV = 8'h01;
  localparam logic [7:0] PS_HDR_COUNT = 8'h01;
  localparam logic [7:0] PS_STD_ID = 8'h00;
  localparam logic [7:0] PS_T0_LEN = 8'h09;
  localparam logic [7:0] PS_T0_PTR = 8'h30;
  localparam logic [7:0] PS_T1_LEN = 8'h04;
  localparam logic [7:0] PS_T1_PTR = 8'h60;
  localparam logic [31:0] PS_SIGNATURE = 32'h5044_4653;
  localparam logic [7:0] PS_HDR_LAST = 8'h17;
  localparam int PS_ADDR_BYTES = 3;
  localparam int PS_DUMMY_BYTES = 1;
  localparam int RESUME_GUARD_US = 1000;
  localparam int SYS_CLK_MHZ = 10;
  localparam int RESUME_GUARD_CYC = RESUME_GUARD_US * SYS_CLK_MHZ;
endpackage

// File: tb/frc_host.sv
/*
  Host controller model: frames commands and parameter-space reads.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/100ps
module frc_host
  import frc_pkg::*;
(
  output logic CS_N,
  output logic SCLK,
  output logic [3:0] SIO_IN,
  input wire logic [3:0] SIO_OUT,
  input wire logic [3:0] SIO_OE
);
  initial begin
    CS_N = 0;
    SCLK = 0;
    SIO_IN = 4'h5;
    // a clean deselect edge after power up clears the link logic
    #1 CS_N = 1;
  end
  task automatic tick;
    #7.5 SCLK = 1;
    #7.5 SCLK = 0;
  endtask
  task automatic put_byte(input logic [7:0] b, input logic quad);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      // junk on the upper lines in single-line mode
      SIO_IN = quad ? (i == 0 ? b[7:4] : b[3:0]) : {{3{~b[7-i]}}, b[7-i]};
      tick();
    end
  endtask
  task automatic xfer(input logic [7:0] op, input logic quad, input int extra);
    CS_N = 0;
    #10;
    put_byte(op, quad);
    repeat (extra) tick();
    #10;
    CS_N = 1;
    // a released line must not keep its last value
    SIO_IN = ~SIO_IN;
  endtask
  task automatic read_ps(input logic [23:0] a, input int n, input int extra,
                         output logic [7:0] q, output logic [3:0] oe);
    q = 8'h00;
    oe = 4'h0;
    CS_N = 0;
    #10;
    put_byte(OP_PSREAD, 1'b0);
    for (int i = 2; i >= 0; i--) begin
      put_byte(a[8*i +: 8], 1'b0);
    end
    put_byte(8'hC3, 1'b0);
    repeat (n) begin
      for (int j = 0; j < 8; j++) begin
        #7.5 SCLK = 1;
        q = {q[6:0], SIO_OUT[1]};
        oe = SIO_OE;
        #7.5 SCLK = 0;
      end
    end
    repeat (extra) tick();
    #10;
    CS_N = 1;
    SIO_IN = ~SIO_IN;
  endtask
endmodule  // frc_host

// File: tb/frc_cmd_test.sv
/*
  Self-checking bench for the command block: header table, resume, reset.
  Assumes the host model frc_host and a short resume guard.
*/
`timescale 1ns/100ps
module frc_cmd_test;
  import frc_pkg::*;
  localparam logic [7:0] MAKER = 8'hA7;  // arbitrary value
  logic sys_clk = 0, nrst = 0, four = 0, enh = 0, program_suspended_flag = 0, erase_suspended_flag = 0, cbusy = 0, wset = 0;
  wire logic cs_n, sclk;
  wire logic [3:0] sio_in, sio_out, sio_oe;
  wire logic [7:0] sec;
  wire logic busy, write_enable_latch, res_p, rst_p, sok;
  int err_count = 0, comparisons = 0;
  logic [7:0] q;
  logic [3:0] oe;
  logic sr, st;
  logic [15:0] rows [0:18] = '{16'h0053, 16'h0146, 16'h0244, 16'h0350, 16'h0400, 16'h0501,
    16'h0601, 16'h07FF, 16'h0800, 16'h0A01, 16'h0B09, 16'h0C30, 16'h0E00, 16'h0FFF,
    {8'h10, MAKER}, 16'h1304, 16'h1460, 16'h17FF, 16'h18FF};
  frc_host i_frc_host (.CS_N(cs_n), .SCLK(sclk), .SIO_IN(sio_in), .SIO_OUT(sio_out),
    .SIO_OE(sio_oe));
  frc_cmd #(.MAKER_ID(MAKER), .GUARD_CYC(20)) i_frc_cmd (.SYS_CLK(sys_clk), .NRST(nrst),
    .SCLK(sclk), .CS_N(cs_n), .SIO_IN(sio_in), .SIO_OUT(sio_out), .SIO_OE(sio_oe),
    .FOUR_LINE_MODE(four), .ENHANCED_MODE(enh), .PROGRAM_SUSPENDED_SET(program_suspended_flag),
    .ERASE_SUSPENDED_SET(erase_suspended_flag), .CORE_BUSY(cbusy), .WRITE_ENABLE_SET(wset),
    .SECURITY_STATUS(sec), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .RESUME_PULSE(res_p),
    .SOFT_RESET_PULSE(rst_p), .SUSPEND_ALLOWED(sok));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // pulses are watched over a window longer than the crossing latency
  task automatic cmd(input logic [7:0] op, input logic qd, input int ex, input logic er,
                     input logic et);
    sr = 0;
    st = 0;
    @(posedge sys_clk) four <= qd;
    @(posedge sys_clk);
    i_frc_host.xfer(op, qd, ex);
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      sr = sr | res_p;
      st = st | rst_p;
    end
    chk({6'h00, sr, st}, {6'h00, er, et});
  endtask
  task automatic rd(input logic [7:0] a, input int n, input int ex);
    @(posedge sys_clk) four <= 1'b0;
    i_frc_host.read_ps({16'h0000, a}, n, ex, q, oe);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic flags(input logic w, input logic [1:0] s);
    @(posedge sys_clk) wset <= w;
    @(posedge sys_clk) {wset, erase_suspended_flag, program_suspended_flag} <= {1'b0, s};
    @(posedge sys_clk) {erase_suspended_flag, program_suspended_flag} <= 2'b00;
    repeat (3) @(posedge sys_clk);
  endtask
  initial begin
    #3000000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 chk({3'h0, busy, write_enable_latch, res_p, rst_p, sok}, 8'h01);
    chk(sec, 8'h00);
    @(posedge sys_clk) nrst <= 1'b1;
    foreach (rows[k]) begin
      rd(rows[k][15:8], 1, 0);
      chk(q, rows[k][7:0]);
      chk({4'h0, oe}, 8'h02);
    end
    rd(8'h12, 2, 0);
    chk(q, 8'h04);
    rd(8'h09, 1, 3);
    chk(q, 8'h00);
    chk({4'h0, sio_oe}, 8'h00);
    @(posedge sys_clk) cbusy <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      flags(1'b1, m ? 2'b10 : 2'b01);
      chk({sec[7:1], write_enable_latch}, m ? 8'h08 : 8'h04);
      cmd(OP_RESUME, m[0], 0, 1'b1, 1'b0);
      chk(sec, 8'h00);
      chk({6'h00, busy, sok}, 8'h02);
      for (int i = 0; i < 40 && sok !== 1'b1; i++) begin
        @(posedge sys_clk);  // guard before the next suspend
      end
      chk({7'h00, sok}, 8'h01);
      if (sok !== 1'b1) end_of_test();
    end
    @(posedge sys_clk) cbusy <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({7'h00, busy}, 8'h00);
    cmd(OP_RESUME, 1'b0, 0, 1'b0, 1'b0);
    flags(1'b0, 2'b01);
    cmd(OP_RESUME, 1'b0, 1, 1'b0, 1'b0);
    @(posedge sys_clk) enh <= 1'b1;
    cmd(OP_RESUME, 1'b0, 0, 1'b0, 1'b0);
    chk(sec, 8'h04);
    @(posedge sys_clk) enh <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmd(OP_RESUME, 1'b0, 0, 1'b1, 1'b0);
    flags(1'b1, 2'b01);
    cmd(OP_RESET, 1'b0, 0, 1'b0, 1'b0);
    cmd(OP_RST_ARM, 1'b0, 0, 1'b0, 1'b0);
    cmd(OP_NOP, 1'b1, 0, 1'b0, 1'b0);
    cmd(OP_RESET, 1'b0, 0, 1'b0, 1'b0);
    chk(sec, 8'h04);
    cmd(OP_RST_ARM, 1'b0, 0, 1'b0, 1'b0);
    cmd(OP_RESET, 1'b0, 3, 1'b0, 1'b0);
    cmd(OP_RST_ARM, 1'b1, 0, 1'b0, 1'b0);
    cmd(OP_RESET, 1'b1, 0, 1'b0, 1'b1);
    chk({sec[7:1], write_enable_latch}, 8'h00);
    repeat (20) @(posedge sys_clk);  // recovery before new commands
    flags(1'b1, 2'b00);
    chk({7'h00, write_enable_latch}, 8'h01);
    cmd(OP_RST_ARM, 1'b0, 0, 1'b0, 1'b0);
    cmd(OP_RESET, 1'b0, 0, 1'b0, 1'b1);
    chk({7'h00, write_enable_latch}, 8'h00);
    end_of_test();
  end
endmodule  // frc_cmd_test
